// ==== core/smbus_cfg_map.svh ====
// constants for the smbus configuration port of the clock buffer
// assumes inclusion by the package only; the design modules use its macros without including it
// Function
// - slave only, one 7-bit address plus direction
// - stop after any full byte ends transfer
// - read returns count then data, host nacks last
// - offset byte sets first register index
// - register 0 holds four output enables, reset one
// - cleared enable forces its output low
// - register 1 bits 7:6 read latched strap mode
// - register 1 bits 4:3 act only when selected
// - register 1 bits 1:0 set amplitude, reset 10
// - register 2 bits 6, 5, 3 and 1 set four edge rates, reset one
`ifndef SMBUS_CFG_MAP_SVH
`define SMBUS_CFG_MAP_SVH

`define SLAVE_ADDR      7'h6A
`define READ_COUNT      8'h03
`define REG_OUT_ENABLE  8'h00
`define REG_PLL_AMP     8'h01
`define REG_EDGE_RATE   8'h02
`define RST_OUT_ENABLE  8'hFF
`define RST_PLL_AMP     8'h06
`define RST_EDGE_RATE   8'hFF
`define WR_MASK_OUT_EN  8'h6A
`define WR_MASK_PLL_AMP 8'h3B
`define WR_MASK_EDGE    8'h6A
`define OUT3_BIT        6
`define OUT2_BIT        5
`define OUT1_BIT        3
`define OUT0_BIT        1
`define SW_SELECT_BIT   5
`define CTRL_HI_BIT     4
`define CTRL_LO_BIT     3
`define LATCH_HI_BIT    7
`define LATCH_LO_BIT    6
`define AMP_HI_BIT      1
`define AMP_LO_BIT      0
`define STRAP_SETTLE    2'h2

`endif

// ==== core/smbus_cfg_pkg.sv ====
// types and helpers shared by the configuration port modules
// assumes smbus_cfg_map.svh is on the include path
`include "smbus_cfg_map.svh"
package smbus_cfg_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX   = 3'b001,
		ST_ACK  = 3'b010,
		ST_TX   = 3'b011,
		ST_RACK = 3'b100
	} link_state_e;

	typedef enum logic [1:0] {
		PH_ADDR   = 2'b00,
		PH_OFFSET = 2'b01,
		PH_COUNT  = 2'b10,
		PH_WDATA  = 2'b11
	} rx_phase_e;

	typedef enum logic [1:0] {
		PLL_LOW_BW  = 2'b00,
		PLL_BYPASS  = 2'b01,
		PLL_HIGH_BW = 2'b10
	} pll_mode_e;

	function automatic pll_mode_e pll_decode(input logic [1:0] code);
		case (code)
			2'b01: pll_decode = PLL_BYPASS;
			2'b11: pll_decode = PLL_HIGH_BW;
			default: pll_decode = PLL_LOW_BW;
		endcase
	endfunction

	function automatic logic [3:0] pick_outputs(input logic [7:0] b);
		pick_outputs = {b[`OUT3_BIT], b[`OUT2_BIT], b[`OUT1_BIT], b[`OUT0_BIT]};
	endfunction
endpackage

// ==== core/cfg_reg_file.sv ====
// three control registers with masked writes and a registered read port
// assumes writes and the strap value come from logic on clk_i
`timescale 1ns/1ps
module cfg_reg_file
	import smbus_cfg_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       wr_en_i,
	input  wire logic [7:0] wr_index_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic [7:0] rd_index_i,
	input  wire logic [1:0] strap_mode_i,
	output logic      [7:0] rd_data_o,
	output logic      [3:0] enable_bits_o,
	output logic            sw_select_o,
	output logic      [1:0] pll_ctrl_o,
	output logic      [1:0] amplitude_o,
	output logic      [3:0] edge_rate_o
);
	logic [7:0] out_en_reg, out_en_next;
	logic [7:0] pll_amp_reg, pll_amp_next;
	logic [7:0] edge_reg, edge_next;
	logic [7:0] rd_data_reg, rd_data_next;

	always_comb begin
		out_en_next = out_en_reg;
		pll_amp_next = pll_amp_reg;
		edge_next = edge_reg;
		if (wr_en_i) begin
			case (wr_index_i)
				`REG_OUT_ENABLE: out_en_next = (out_en_reg & ~`WR_MASK_OUT_EN) |
					(wr_data_i & `WR_MASK_OUT_EN);
				// latched readback bits sit outside the mask
				`REG_PLL_AMP: pll_amp_next = (pll_amp_reg & ~`WR_MASK_PLL_AMP) |
					(wr_data_i & `WR_MASK_PLL_AMP);
				`REG_EDGE_RATE: edge_next = (edge_reg & ~`WR_MASK_EDGE) |
					(wr_data_i & `WR_MASK_EDGE);
				default: ;
			endcase
		end
		case (rd_index_i)
			`REG_OUT_ENABLE: rd_data_next = out_en_reg;
			`REG_PLL_AMP: rd_data_next = {strap_mode_i, pll_amp_reg[5:0]};
			`REG_EDGE_RATE: rd_data_next = edge_reg;
			default: rd_data_next = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			out_en_reg <= `RST_OUT_ENABLE;
			pll_amp_reg <= `RST_PLL_AMP;
			edge_reg <= `RST_EDGE_RATE;
			rd_data_reg <= 8'h00;
		end else begin
			out_en_reg <= out_en_next;
			pll_amp_reg <= pll_amp_next;
			edge_reg <= edge_next;
			rd_data_reg <= rd_data_next;
		end
	end

	assign rd_data_o = rd_data_reg;
	assign enable_bits_o = pick_outputs(out_en_reg);
	assign sw_select_o = pll_amp_reg[`SW_SELECT_BIT];
	assign pll_ctrl_o = {pll_amp_reg[`CTRL_HI_BIT], pll_amp_reg[`CTRL_LO_BIT]};
	assign amplitude_o = {pll_amp_reg[`AMP_HI_BIT], pll_amp_reg[`AMP_LO_BIT]};
	assign edge_rate_o = pick_outputs(edge_reg);

	a_latch_not_written: assert property (@(posedge clk_i) disable iff (reset_i)
		wr_en_i && wr_index_i == `REG_PLL_AMP |=> pll_amp_reg[7:6] == $past(pll_amp_reg[7:6]))
		else $error("readback bits stored a write");
	a_amp_write_lands: assert property (@(posedge clk_i) disable iff (reset_i)
		wr_en_i && wr_index_i == `REG_PLL_AMP |=> amplitude_o == $past(wr_data_i[1:0]))
		else $error("amplitude write lost");
endmodule

// ==== core/smbus_clock_buffer_config.sv ====
// smbus slave configuration port: bit engine, block protocol, mode logic
// assumes scl/sda and pins are asynchronous; scl far slower than clk_i
`timescale 1ns/1ps
module smbus_clock_buffer_config
	import smbus_cfg_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_n_o,
	input  wire logic [1:0] pll_mode_strap_i,
	input  wire logic [3:0] out_enable_n_i,
	output logic      [3:0] out_enable_o,
	output pll_mode_e       pll_mode_o,
	output logic      [1:0] amplitude_o,
	output logic      [3:0] edge_rate_o
);
	logic        scl_meta_reg, scl_sync_reg, scl_last_reg;
	logic        sda_meta_reg, sda_sync_reg, sda_last_reg;
	logic [1:0]  strap_meta_reg, strap_sync_reg;
	logic [3:0]  oe_n_meta_reg, oe_n_sync_reg;
	logic        scl_rise, scl_fall, start_det, stop_det;

	link_state_e state_reg, state_next;
	rx_phase_e   phase_reg, phase_next;
	logic [3:0]  bit_cnt_reg, bit_cnt_next;
	logic [7:0]  shift_reg, shift_next;
	logic [7:0]  index_reg, index_next;
	logic [7:0]  remain_reg, remain_next;
	logic        tx_after_reg, tx_after_next;
	logic        sent_count_reg, sent_count_next;
	logic        host_ack_reg, host_ack_next;
	logic [1:0]  strap_cnt_reg, strap_cnt_next;
	logic [1:0]  latched_reg, latched_next;
	logic        wr_en, load_tx;
	logic [7:0]  rd_data;
	logic [3:0]  enable_bits;
	logic        sw_select;
	logic [1:0]  pll_ctrl;

	// edges come from the second and third stages only
	assign scl_rise = scl_sync_reg & ~scl_last_reg;
	assign scl_fall = ~scl_sync_reg & scl_last_reg;
	assign start_det = scl_sync_reg & scl_last_reg & sda_last_reg & ~sda_sync_reg;
	assign stop_det = scl_sync_reg & scl_last_reg & ~sda_last_reg & sda_sync_reg;

	always_comb begin
		state_next = state_reg;
		phase_next = phase_reg;
		bit_cnt_next = bit_cnt_reg;
		shift_next = shift_reg;
		index_next = index_reg;
		remain_next = remain_reg;
		tx_after_next = tx_after_reg;
		sent_count_next = sent_count_reg;
		host_ack_next = host_ack_reg;
		wr_en = 1'b0;
		load_tx = 1'b0;
		if (stop_det) begin
			state_next = ST_IDLE;
		end else if (start_det) begin
			state_next = ST_RX;
			phase_next = PH_ADDR;
			bit_cnt_next = 4'h0;
		end else begin
			case (state_reg)
				ST_IDLE: ;
				ST_RX: begin
					if (scl_rise && bit_cnt_reg != 4'h8) begin
						shift_next = {shift_reg[6:0], sda_sync_reg};
						bit_cnt_next = bit_cnt_reg + 4'h1;
					end else if (scl_fall && bit_cnt_reg == 4'h8) begin
						state_next = ST_ACK;
						tx_after_next = 1'b0;
						case (phase_reg)
							PH_ADDR: begin
								if (shift_reg[7:1] != `SLAVE_ADDR) begin
									state_next = ST_IDLE;
								end else if (shift_reg[0]) begin
									tx_after_next = 1'b1;
									sent_count_next = 1'b0;
								end else begin
									phase_next = PH_OFFSET;
								end
							end
							PH_OFFSET: begin
								index_next = shift_reg;
								phase_next = PH_COUNT;
							end
							PH_COUNT: begin
								remain_next = shift_reg;
								phase_next = PH_WDATA;
							end
							default: begin
								// bytes past the announced count are acked but dropped
								if (remain_reg != 8'h00) begin
									wr_en = 1'b1;
									index_next = index_reg + 8'h01;
									remain_next = remain_reg - 8'h01;
								end
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bit_cnt_next = 4'h0;
						if (tx_after_reg) begin
							load_tx = 1'b1;
						end else begin
							state_next = ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt_reg == 4'h7) begin
							state_next = ST_RACK;
						end else begin
							shift_next = {shift_reg[6:0], 1'b1};
							bit_cnt_next = bit_cnt_reg + 4'h1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						host_ack_next = ~sda_sync_reg;
					end else if (scl_fall) begin
						bit_cnt_next = 4'h0;
						if (host_ack_reg) begin
							load_tx = 1'b1;
						end else begin
							state_next = ST_IDLE;
						end
					end
				end
				default: state_next = ST_IDLE;
			endcase
		end
		if (load_tx) begin
			state_next = ST_TX;
			shift_next = sent_count_reg ? rd_data : `READ_COUNT;
			sent_count_next = 1'b1;
			if (sent_count_reg) begin
				index_next = index_reg + 8'h01;
			end
		end
	end

	// strap is caught once, after the synchroniser has settled
	always_comb begin
		strap_cnt_next = strap_cnt_reg;
		latched_next = latched_reg;
		if (strap_cnt_reg != 2'h3) begin
			strap_cnt_next = strap_cnt_reg + 2'h1;
		end
		if (strap_cnt_reg == `STRAP_SETTLE) begin
			latched_next = strap_sync_reg;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			scl_meta_reg <= 1'b1;
			scl_sync_reg <= 1'b1;
			scl_last_reg <= 1'b1;
			sda_meta_reg <= 1'b1;
			sda_sync_reg <= 1'b1;
			sda_last_reg <= 1'b1;
			strap_meta_reg <= 2'h0;
			strap_sync_reg <= 2'h0;
			oe_n_meta_reg <= 4'hF;
			oe_n_sync_reg <= 4'hF;
			state_reg <= ST_IDLE;
			phase_reg <= PH_ADDR;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			index_reg <= 8'h00;
			remain_reg <= 8'h00;
			tx_after_reg <= 1'b0;
			sent_count_reg <= 1'b0;
			host_ack_reg <= 1'b0;
			strap_cnt_reg <= 2'h0;
			latched_reg <= 2'h0;
		end else begin
			scl_meta_reg <= scl_i;
			scl_sync_reg <= scl_meta_reg;
			scl_last_reg <= scl_sync_reg;
			sda_meta_reg <= sda_i;
			sda_sync_reg <= sda_meta_reg;
			sda_last_reg <= sda_sync_reg;
			strap_meta_reg <= pll_mode_strap_i;
			strap_sync_reg <= strap_meta_reg;
			oe_n_meta_reg <= out_enable_n_i;
			oe_n_sync_reg <= oe_n_meta_reg;
			state_reg <= state_next;
			phase_reg <= phase_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg <= shift_next;
			index_reg <= index_next;
			remain_reg <= remain_next;
			tx_after_reg <= tx_after_next;
			sent_count_reg <= sent_count_next;
			host_ack_reg <= host_ack_next;
			strap_cnt_reg <= strap_cnt_next;
			latched_reg <= latched_next;
		end
	end

	cfg_reg_file cfg_reg_file_i (
		.clk_i         (clk_i),
		.reset_i       (reset_i),
		.wr_en_i       (wr_en),
		.wr_index_i    (index_reg),
		.wr_data_i     (shift_reg),
		.rd_index_i    (index_reg),
		.strap_mode_i  (latched_reg),
		.rd_data_o     (rd_data),
		.enable_bits_o (enable_bits),
		.sw_select_o   (sw_select),
		.pll_ctrl_o    (pll_ctrl),
		.amplitude_o   (amplitude_o),
		.edge_rate_o   (edge_rate_o)
	);

	// open drain: only ever pull low, never drive high
	assign sda_o = 1'b0;
	assign sda_oe_n_o = ~((state_reg == ST_ACK) || (state_reg == ST_TX && !shift_reg[7]));
	assign out_enable_o = enable_bits & ~oe_n_sync_reg;
	assign pll_mode_o = pll_decode(sw_select ? pll_ctrl : latched_reg);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	a_idle_never_drives: assert property (state_reg == ST_IDLE |-> sda_oe_n_o)
		else $error("sda pulled while idle");
	a_stop_ends_xfer: assert property (stop_det |=> state_reg == ST_IDLE)
		else $error("stop did not end transfer");
	a_ack_pulls_low: assert property ($rose(state_reg == ST_ACK) |-> !sda_oe_n_o)
		else $error("byte not acknowledged");
	a_nack_releases: assert property (state_reg == ST_RACK && scl_fall && !host_ack_reg
		|=> state_reg == ST_IDLE ##1 sda_oe_n_o)
		else $error("host nack did not end read");
	a_offset_sets_index: assert property (state_reg == ST_RX && phase_reg == PH_OFFSET
		&& scl_fall && bit_cnt_reg == 4'h8 |=> index_reg == $past(shift_reg))
		else $error("offset not taken as index");
	a_index_steps: assert property (wr_en |=> index_reg == $past(index_reg) + 8'h01)
		else $error("index did not advance");
	a_disabled_low: assert property ((out_enable_o & ~enable_bits) == 4'h0)
		else $error("disabled output running");
	a_ctrl_gated: assert property (!sw_select && $changed(pll_ctrl)
		|-> pll_mode_o == pll_decode(latched_reg))
		else $error("control bits acted while unselected");
	a_latch_holds: assert property (strap_cnt_reg == 2'h3 |=> $stable(latched_reg))
		else $error("latched mode moved");

	c_block_write: cover property (wr_en ##[1:300] stop_det);
	c_block_read: cover property (load_tx && sent_count_reg ##[1:300] state_reg == ST_RACK);
	c_read_nack: cover property (state_reg == ST_RACK && scl_fall && !host_ack_reg);
	c_sw_mode: cover property (sw_select && pll_mode_o == PLL_BYPASS);
endmodule

// ==== sim/smbus_host_model.sv ====
// smbus host: drives scl and a data line that it releases high
// assumes the bench resolves the open-drain wire with a pull-up
`timescale 1ns/1ps
module smbus_host_model (
	output logic      scl_o,
	output logic      sda_o,
	input  wire logic sda_i
);
	// scl stands high between frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic start();
		sda_o = 1'b1;
		#200;
		sda_o = 1'b0;
		#200;
		scl_o = 1'b0;
		#100;
	endtask
	// long phases so the device drops its ack before scl rises
	task automatic rstart();
		sda_o = 1'b1;
		#200;
		scl_o = 1'b1;
		#200;
		sda_o = 1'b0;
		#200;
		scl_o = 1'b0;
		#100;
	endtask
	task automatic stop();
		sda_o = 1'b0;
		#100;
		scl_o = 1'b1;
		#100;
		sda_o = 1'b1;
		#400;
	endtask
	// sample mid-high: the device answers up to 150 ns after scl falls
	task automatic bit_io(input logic b, output logic r);
		sda_o = b;
		#100;
		scl_o = 1'b1;
		#100;
		r = sda_i;
		#100;
		scl_o = 1'b0;
		#100;
	endtask
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, ack);
	endtask
	task automatic get(output logic [7:0] d, input logic nack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(nack, r);
	endtask
endmodule

// ==== sim/smbus_clock_buffer_config_bench.sv ====
// self-checking bench for the smbus configuration port
// assumes the host model above; sda is open drain with a pull-up
`timescale 1ns/1ps
module smbus_clock_buffer_config_bench;
	import smbus_cfg_pkg::*;
	logic       clk_i = 1'b0;
	logic       reset_i;
	logic       scl;
	logic       host_sda;
	logic       dev_sda;
	logic       dev_oe_n;
	logic [1:0] strap;
	logic [3:0] pins_n;
	logic [3:0] out_en;
	pll_mode_e  pll_mode;
	logic [1:0] amp;
	logic [3:0] edge_rate;
	logic [7:0] rd [3];
	int         fails = 0;
	int         check_count = 0;
	wire        sda_line = host_sda & (dev_oe_n ? 1'b1 : dev_sda);

	always #25 clk_i = ~clk_i;

	smbus_clock_buffer_config smbus_clock_buffer_config_i (
		.clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda_line),
		.sda_o(dev_sda), .sda_oe_n_o(dev_oe_n), .pll_mode_strap_i(strap),
		.out_enable_n_i(pins_n), .out_enable_o(out_en), .pll_mode_o(pll_mode),
		.amplitude_o(amp), .edge_rate_o(edge_rate)
	);
	smbus_host_model smbus_host_model_i (.scl_o(scl), .sda_o(host_sda), .sda_i(sda_line));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic outs(input logic [3:0] e, input pll_mode_e m, input logic [1:0] a,
			input logic [3:0] s);
		repeat (10) @(negedge clk_i);
		check({4'h0, out_en}, {4'h0, e});
		check({6'h00, pll_mode}, {6'h00, m});
		check({6'h00, amp}, {6'h00, a});
		check({4'h0, edge_rate}, {4'h0, s});
	endtask
	task automatic wr_blk(input logic [7:0] off, input logic [7:0] n, input int sent,
			input logic [7:0] d0, input logic [7:0] d1, input logic [7:0] d2);
		logic       a;
		logic [7:0] d [3];
		d = '{d0, d1, d2};
		smbus_host_model_i.start();
		smbus_host_model_i.put(8'hD4, a);
		check({7'h00, a}, 8'h00);
		smbus_host_model_i.put(off, a);
		check({7'h00, a}, 8'h00);
		smbus_host_model_i.put(n, a);
		check({7'h00, a}, 8'h00);
		for (int i = 0; i < sent; i++) begin
			smbus_host_model_i.put(d[i], a);
			check({7'h00, a}, 8'h00);
		end
		smbus_host_model_i.stop();
	endtask
	task automatic rd_blk(input logic [7:0] off, input int n);
		logic       a;
		logic [7:0] cnt;
		smbus_host_model_i.start();
		smbus_host_model_i.put(8'hD4, a);
		smbus_host_model_i.put(off, a);
		smbus_host_model_i.rstart();
		smbus_host_model_i.put(8'hD5, a);
		check({7'h00, a}, 8'h00);
		smbus_host_model_i.get(cnt, n == 0);
		check(cnt, 8'h03);
		for (int i = 0; i < n; i++) smbus_host_model_i.get(rd[i], i == n - 1);
		smbus_host_model_i.stop();
	endtask
	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#2000000;
		fails++;
		give_verdict();
	end

	initial begin
		logic       a;
		logic [1:0] c;
		pll_mode_e  exp_m [4];
		exp_m = '{PLL_LOW_BW, PLL_BYPASS, PLL_LOW_BW, PLL_HIGH_BW};
		reset_i = 1'b1;
		strap = 2'b01;
		pins_n = 4'h0;
		repeat (20) @(posedge clk_i);
		@(negedge clk_i) reset_i = 1'b0;
		outs(4'hF, PLL_BYPASS, 2'b10, 4'hF);
		rd_blk(8'h00, 3);
		check(rd[0], 8'hFF);
		check(rd[1], 8'h46);
		check(rd[2], 8'hFF);
		$display("reset values done");
		wr_blk(8'h00, 8'h03, 3, 8'h00, 8'hFF, 8'h00);
		outs(4'h0, PLL_HIGH_BW, 2'b11, 4'h0);
		rd_blk(8'h00, 3);
		check(rd[0], 8'h95);
		check(rd[1], 8'h7F);
		check(rd[2], 8'h95);
		$display("block write done");
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			wr_blk(8'h01, 8'h01, 1, {2'b00, 1'b1, c, 3'b010}, 8'h00, 8'h00);
			outs(4'h0, exp_m[i], 2'b10, 4'h0);
		end
		// software bits ignored once the source is back on the strap
		wr_blk(8'h01, 8'h01, 1, 8'h12, 8'h00, 8'h00);
		outs(4'h0, PLL_BYPASS, 2'b10, 4'h0);
		$display("mode codes done");
		wr_blk(8'h00, 8'h02, 1, 8'hFF, 8'h00, 8'h00);
		@(negedge clk_i) pins_n = 4'b0101;
		// a strap that moves after power-up must not reach the latched mode
		strap = 2'h3;
		wr_blk(8'h02, 8'h01, 1, 8'h40, 8'h00, 8'h00);
		outs(4'b1010, PLL_BYPASS, 2'b10, 4'b1000);
		smbus_host_model_i.start();
		smbus_host_model_i.put(8'hD6, a);
		check({7'h00, a}, 8'h01);
		smbus_host_model_i.stop();
		rd_blk(8'h01, 2);
		check(rd[0], 8'h56);
		check(rd[1], 8'hD5);
		$display("early stop and pins done");
		give_verdict();
	end
endmodule
